// >>> design/ipma_bridge.sv
// indirect host access bridge to private memory and local registers
//
// Contract
// - private memory is 64 KB to 1 MB, reached by 20-bit address.
// - SRAM at 00000h-0FFFFh, ROM from E0000h to FFFFFh.
// - one 64 KB block visible at once, chosen by page select.
// - page codes: SRAM all zero, ROM low 1110000, ROM high 1111000.
// - command: opcode in 31:26, zeros in 25:20, address in 19:0.
// - opcode picks target class and direction; bit 27 picks byte/word.
// - command address is driven onto the local address bus.
// - private read opcode starts access; host then reads the data port. The bridge starts the local read only on the data port read.
// - data access of the wrong direction ends in target abort.
// - writes allowed from region origin up to top of memory.
// - writes allowed in window from open address below close address.
// - boundaries are word aligned; low address bit reads zero.
// - before the adapter opens, private memory is read-only; the bridge lets private writes through while attention bit 6 is set.
// - after init one writable region FE90h-FFFFh, rest protected.
// - attention bit 7 unlocks page register, else read-only.
// - attention bit 6 makes all shared memory writable.
// - data reads retry until slow read data is ready.
// - byte reads return data in bits 7:0; upper bits undefined.
// - data port access of a write command triggers the local write.
// - page register holds page select in bits 8:2.
`default_nettype none

module ipma_bridge (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // host register port
  input  wire ipma_pkg::ipma_host_req_t hostReq,
  output ipma_pkg::ipma_host_rsp_t      hostRsp,
  // local bus of the mac chip
  output ipma_pkg::ipma_loc_req_t       locReq,
  input  wire logic                     locReady,
  input  wire logic [15:0]              locRdata,
  // adapter state
  input  wire logic                     adapterOpen,
  output logic [6:0]                    pageSelect
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PEND = 5'b00010,
    ST_LRD  = 5'b00100,
    ST_RDY  = 5'b01000,
    ST_LWR  = 5'b10000
  } ipma_state_t;

  ipma_state_t              stReg;
  ipma_state_t              stNext;
  logic [31:0]              cmdReg;
  logic [7:0]               attnReg;
  logic [15:0]              pageReg;
  logic [15:0]              regionReg;
  logic [15:0]              wopenReg;
  logic [15:0]              wcloseReg;
  logic [15:0]              rdDataReg;
  logic                     openSeenReg;
  ipma_pkg::ipma_loc_req_t  locReg;
  ipma_pkg::ipma_host_rsp_t rspReg;
  ipma_pkg::ipma_host_rsp_t rspNext;

  // host access decode
  logic        hitCmd;
  logic        hitData;
  logic        cmdTake;
  logic [31:0] cmdClean;

  assign hitCmd   = hostReq.req && (hostReq.addr == ipma_pkg::OFS_CMD_WORD);
  assign hitData  = hostReq.req && (hostReq.addr == ipma_pkg::OFS_DATA_PORT);
  assign cmdTake  = hitCmd && hostReq.wr && (stReg == ST_IDLE);

  assign cmdClean = {hostReq.wdata[31:26], 6'h00, hostReq.wdata[19:0]};

  // command decode
  logic        cmdRead;
  logic        cmdWrite;
  logic        cmdIo;
  logic        cmdPriv;
  logic        cmdWord;
  logic [19:0] cmdAddr;

  assign cmdRead  = cmdReg[ipma_pkg::OPB_MEM_RD] || cmdReg[ipma_pkg::OPB_IO_RD];
  assign cmdWrite = cmdReg[ipma_pkg::OPB_MEM_WR] || cmdReg[ipma_pkg::OPB_IO_WR];
  assign cmdIo    = cmdReg[ipma_pkg::OPB_IO_RD] || cmdReg[ipma_pkg::OPB_IO_WR];
  assign cmdPriv  = cmdReg[ipma_pkg::OPB_PRIV] && !cmdIo;
  assign cmdWord  = cmdReg[ipma_pkg::OPB_WORD];
  assign cmdAddr  = cmdReg[ipma_pkg::ADDR_HI:0];

  // registers held in the bridge rather than on the local bus
  logic tgtAttn;
  logic tgtPage;
  logic tgtRegion;
  logic tgtWopen;
  logic tgtWclose;
  logic tgtInt;
  logic mmio;

  assign mmio      = !cmdIo && !cmdPriv;
  assign tgtAttn   = cmdIo && (cmdAddr == ipma_pkg::IO_ATTN_ADDR);
  assign tgtPage   = cmdIo && (cmdAddr == ipma_pkg::IO_PAGE_ADDR);
  assign tgtRegion = mmio && (cmdAddr == ipma_pkg::MM_REGION_ADDR);
  assign tgtWopen  = mmio && (cmdAddr == ipma_pkg::MM_WOPEN_ADDR);
  assign tgtWclose = mmio && (cmdAddr == ipma_pkg::MM_WCLOSE_ADDR);
  assign tgtInt    = tgtAttn || tgtPage || tgtRegion || tgtWopen || tgtWclose;

  logic [15:0] intRdata;

  assign intRdata = tgtAttn   ? {8'h00, attnReg} :
                    tgtPage   ? pageReg :
                    tgtRegion ? regionReg :
                    tgtWopen  ? wopenReg :
                    tgtWclose ? wcloseReg : 16'h0000;

  // page select and visible block
  logic [19:0] memAddr;
  logic        sramPage;

  assign pageSelect = pageReg[ipma_pkg::PAGE_HI:ipma_pkg::PAGE_LO];
  assign sramPage   = pageSelect == ipma_pkg::PAGE_SRAM;
  // one 64 KB block, rom pages land at E0000h/F0000h
  assign memAddr    = {pageSelect[6:3], cmdAddr[15:0]};

  // write protection
  logic wrAllowed;
  logic override;

  assign override = attnReg[ipma_pkg::ATTN_OVERRIDE];

  ipma_wprot u_wprot (
    .offset    (cmdAddr[15:0]),
    .sramPage  (sramPage),
    .regionReg (regionReg),
    .wopenReg  (wopenReg),
    .wcloseReg (wcloseReg),
    .opened    (adapterOpen),
    .override  (override),
    .allowed   (wrAllowed)
  );

  // data port events
  logic dataRdOk;
  logic dataWrOk;
  logic mismatch;
  logic wrDrop;
  logic wrLocal;
  logic rdLocal;
  logic intWr;
  logic unlock;

  assign dataRdOk = hitData && !hostReq.wr && cmdRead;
  assign dataWrOk = hitData && hostReq.wr && cmdWrite;
  assign mismatch = hitData && (stReg != ST_LWR) && (stReg != ST_LRD || hostReq.wr)
                    && !((stReg == ST_PEND || stReg == ST_RDY) && (dataRdOk || dataWrOk));
  assign rdLocal  = (stReg == ST_PEND) && dataRdOk && !tgtInt;
  assign intWr    = (stReg == ST_PEND) && dataWrOk && tgtInt;
  assign wrDrop   = (stReg == ST_PEND) && dataWrOk && cmdPriv && !wrAllowed;
  assign wrLocal  = (stReg == ST_PEND) && dataWrOk && !tgtInt && !wrDrop;
  assign unlock   = attnReg[ipma_pkg::ATTN_UNLOCK];

  // byte read lands in bits 7:0
  logic [15:0] locData;

  assign locData = cmdWord ? locRdata :
                   {8'h00, (cmdAddr[0] ? locRdata[15:8] : locRdata[7:0])};

  // sequencer
  always_comb begin
    stNext  = stReg;
    rspNext = '0;
    if (hitCmd) begin
      rspNext.ack   = !hostReq.wr || (stReg == ST_IDLE);
      rspNext.retry = hostReq.wr && (stReg != ST_IDLE);
      rspNext.rdata = cmdReg;
      if (cmdTake) begin
        stNext = ST_PEND;
      end
    end else if (hitData) begin
      if (mismatch) begin
        rspNext.abort = 1'b1;
        stNext        = ST_IDLE;
      end else begin
        unique case (stReg)
          ST_PEND: begin
            rspNext.ack   = !rdLocal;
            rspNext.retry = rdLocal;
            rspNext.rdata = {16'h0000, intRdata};
            // read launched by data port read
            stNext        = rdLocal ? ST_LRD : (wrLocal ? ST_LWR : ST_IDLE);
          end
          ST_RDY: begin
            rspNext.ack   = 1'b1;
            rspNext.rdata = {16'h0000, rdDataReg};
            stNext        = ST_IDLE;
          end
          ST_LRD, ST_LWR: begin
            rspNext.retry = 1'b1;
          end
          ST_IDLE: begin
            rspNext.abort = 1'b1;
          end
        endcase
      end
    end else if (hostReq.req) begin
      rspNext.ack = 1'b1;
    end
    if ((stReg == ST_LRD) && locReady) begin
      stNext = ST_RDY;
    end
    if ((stReg == ST_LWR) && locReady) begin
      stNext = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stReg  <= ST_IDLE;
      rspReg <= '0;
    end else begin
      stReg  <= stNext;
      rspReg <= rspNext;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmdReg <= ipma_pkg::CMD_RESET;
    end else if (cmdTake) begin
      cmdReg <= cmdClean;
    end
  end

  // local bus request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      locReg <= '0;
    end else if (rdLocal || wrLocal) begin
      locReg.valid   <= 1'b1;
      locReg.write   <= wrLocal;
      locReg.word    <= cmdWord;
      locReg.isIo    <= cmdIo;
      locReg.isPriv  <= cmdPriv;
      locReg.addr    <= cmdAddr;
      locReg.memAddr <= memAddr;
      // data port write triggers the write
      locReg.wdata   <= hostReq.wdata[15:0];
    end else if (locReady) begin
      locReg.valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdDataReg <= 16'h0000;
    end else if ((stReg == ST_LRD) && locReady) begin
      rdDataReg <= locData;
    end
  end

  // firmware attention and page base
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      attnReg <= ipma_pkg::ATTN_RESET;
      pageReg <= ipma_pkg::PAGE_RESET;
    end else begin
      if (intWr && tgtAttn) begin
        attnReg <= hostReq.wdata[7:0];
      end
      if (intWr && tgtPage && unlock) begin
        pageReg <= (pageReg & ~ipma_pkg::PAGE_WMASK) | (hostReq.wdata[15:0] & ipma_pkg::PAGE_WMASK);
      end
    end
  end

  // boundary registers
  logic        openRise;
  logic        bndWr;
  logic [15:0] bndData;
  logic [15:0] fwRegion;

  assign openRise = adapterOpen && !openSeenReg;
  assign bndWr    = intWr && override;
  // bit 8 holds the low address bit
  assign bndData  = hostReq.wdata[15:0] & ipma_pkg::BND_ALIGN_MASK;
  assign fwRegion = {ipma_pkg::FW_REGION_ORG[7:0], ipma_pkg::FW_REGION_ORG[15:8]};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      openSeenReg <= 1'b0;
      regionReg   <= ipma_pkg::BND_RESET;
      wopenReg    <= ipma_pkg::BND_RESET;
      wcloseReg   <= ipma_pkg::BND_RESET;
    end else begin
      openSeenReg <= adapterOpen;
      if (openRise) begin
        regionReg <= fwRegion & ipma_pkg::BND_ALIGN_MASK;
        wopenReg  <= ipma_pkg::BND_RESET;
        wcloseReg <= ipma_pkg::BND_RESET;
      end else if (bndWr) begin
        if (tgtRegion) begin
          regionReg <= bndData;
        end
        if (tgtWopen) begin
          wopenReg <= bndData;
        end
        if (tgtWclose) begin
          wcloseReg <= bndData;
        end
      end
    end
  end

  assign hostRsp = rspReg;
  assign locReq  = locReg;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_wr_cmd_pending;
    stReg != ST_IDLE && hitCmd && hostReq.wr;
  endsequence

  sequence s_priv_write;
    stReg == ST_PEND && dataWrOk && cmdPriv && !tgtInt;
  endsequence

  sequence s_local_read_done;
    stReg == ST_LRD && locReady ##1 stReg == ST_RDY;
  endsequence

  a_cmd_hold_pending: assert property (
    s_wr_cmd_pending |=> hostRsp.retry && $stable(cmdReg))
    else $error("command taken while one was pending");

  a_mismatch_abort: assert property (
    stReg == ST_PEND && hitData && (hostReq.wr != cmdWrite) |=> hostRsp.abort && stReg == ST_IDLE)
    else $error("mismatched data access not aborted");

  a_slow_read_retry: assert property (
    stReg == ST_LRD && hitData && !hostReq.wr && !locReady |=> hostRsp.retry && !hostRsp.ack)
    else $error("data read answered before data ready");

  a_read_result: assert property (
    s_local_read_done ##0 (hitData && !hostReq.wr) |=> hostRsp.ack && hostRsp.rdata[15:0] == rdDataReg)
    else $error("read result not returned");

  a_loc_addr_drive: assert property (
    locReq.valid |-> locReq.addr == cmdAddr && locReq.memAddr[15:0] == cmdAddr[15:0])
    else $error("local address differs from command");

  a_page_lock: assert property (
    $changed(pageReg) |-> $past(unlock))
    else $error("page register changed while locked");

  a_closed_read_only: assert property (
    (!adapterOpen && !override) and s_priv_write |=> !locReq.valid)
    else $error("private write before adapter open");

  a_override_write: assert property (
    override and s_priv_write |=> locReq.valid && locReq.write && stReg == ST_LWR)
    else $error("override did not permit write");

  a_write_trigger: assert property (
    wrLocal |=> locReq.valid && locReq.write && locReq.wdata == $past(hostReq.wdata[15:0]))
    else $error("data port write did not start local write");

  a_byte_low_lane: assert property (
    stReg == ST_LRD && locReady && !cmdWord |=> rdDataReg[15:8] == 8'h00)
    else $error("byte read not in low lane");

  a_bnd_aligned: assert property (
    !regionReg[8] && !wopenReg[8] && !wcloseReg[8])
    else $error("boundary not word aligned");

  a_cmd_zero_field: assert property (
    cmdTake |=> cmdReg[ipma_pkg::ZERO_HI:ipma_pkg::ZERO_LO] == 6'h00)
    else $error("reserved command bits kept");

  a_init_region: assert property (
    openRise |=> regionReg == fwRegion && wopenReg == wcloseReg)
    else $error("initial write region wrong");

endmodule : ipma_bridge

`default_nettype wire

// >>> design/ipma_wprot.sv
// write-protection check for host writes into private memory
`default_nettype none

module ipma_wprot (
  // target of the write
  input  wire logic [15:0] offset,
  input  wire logic        sramPage,
  // boundary registers, low byte in [15:8]
  input  wire logic [15:0] regionReg,
  input  wire logic [15:0] wopenReg,
  input  wire logic [15:0] wcloseReg,
  // state
  input  wire logic        opened,
  input  wire logic        override,
  // verdict
  output logic             allowed
);

  logic [15:0] regionOrg;
  logic [15:0] winOpen;
  logic [15:0] winClose;
  logic        inRegion;
  logic        inWindow;

  assign regionOrg = {regionReg[7:0], regionReg[15:8]};
  assign winOpen   = {wopenReg[7:0], wopenReg[15:8]};
  assign winClose  = {wcloseReg[7:0], wcloseReg[15:8]};

  assign inRegion  = offset >= regionOrg;
  assign inWindow  = (offset >= winOpen) && (offset < winClose);

  assign allowed   = override || (opened && sramPage && (inRegion || inWindow));

endmodule : ipma_wprot

`default_nettype wire

// >>> pkg/ipma_pkg.sv
// constants and carriers for the indirect private memory bridge
`default_nettype none

package ipma_pkg;

  // host register offsets
  localparam logic [7:0]  OFS_DATA_PORT  = 8'h10;
  localparam logic [7:0]  OFS_CMD_WORD   = 8'h14;

  // local addresses of the registers kept inside the bridge
  localparam logic [19:0] IO_ATTN_ADDR   = 20'h0180D;
  localparam logic [19:0] IO_PAGE_ADDR   = 20'h01C80;
  localparam logic [19:0] MM_REGION_ADDR = 20'hCDE02;
  localparam logic [19:0] MM_WOPEN_ADDR  = 20'hCDE04;
  localparam logic [19:0] MM_WCLOSE_ADDR = 20'hCDE06;

  // command word fields
  localparam int          OPB_MEM_RD     = 31;
  localparam int          OPB_MEM_WR     = 30;
  localparam int          OPB_IO_RD      = 29;
  localparam int          OPB_IO_WR      = 28;
  localparam int          OPB_WORD       = 27;
  localparam int          OPB_PRIV       = 26;
  localparam int          ADDR_HI        = 19;
  localparam int          ZERO_HI        = 25;
  localparam int          ZERO_LO        = 20;

  // page base register
  localparam int          PAGE_HI        = 8;
  localparam int          PAGE_LO        = 2;
  localparam logic [15:0] PAGE_RESET     = 16'h1000;
  localparam logic [15:0] PAGE_WMASK     = 16'h0FFC;
  localparam logic [6:0]  PAGE_SRAM      = 7'h00;
  localparam logic [6:0]  PAGE_ROM_LO    = 7'h70;
  localparam logic [6:0]  PAGE_ROM_HI    = 7'h78;

  // firmware attention register
  localparam int          ATTN_UNLOCK    = 7;
  localparam int          ATTN_OVERRIDE  = 6;
  localparam logic [7:0]  ATTN_RESET     = 8'h00;

  // write-protection boundaries, stored low byte in [15:8]
  localparam logic [15:0] BND_RESET      = 16'h0000;
  localparam logic [15:0] BND_ALIGN_MASK = 16'hFEFF;
  localparam logic [15:0] FW_REGION_ORG  = 16'hFE90;
  localparam logic [31:0] CMD_RESET      = 32'h0000_0000;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ipma_host_req_t;

  typedef struct packed {
    logic        ack;
    logic        retry;
    logic        abort;
    logic [31:0] rdata;
  } ipma_host_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic        isIo;
    logic        isPriv;
    logic [19:0] addr;
    logic [19:0] memAddr;
    logic [15:0] wdata;
  } ipma_loc_req_t;

endpackage : ipma_pkg

`default_nettype wire

// >>> sim/ipma_loc_model.sv
// behavioural model of the mac chip local bus seen by the bridge
`default_nettype none

module ipma_loc_model (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // local bus
  input  wire ipma_pkg::ipma_loc_req_t locReq,
  output logic                         locReady,
  output logic [15:0]                  locRdata,
  // answer delay in cycles
  input  wire logic [3:0]              latency
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [int];
  logic [3:0]  waitCnt;
  logic [15:0] noise;
  int          key;

  // paged physical address for private memory
  assign key = locReq.isPriv ? int'(locReq.memAddr >> 1) : int'(locReq.addr >> 1);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      locReady <= 1'b0;
      waitCnt <= 4'h0;
      noise <= 16'hA55A;
      locRdata <= 16'h0000;
    end else begin
      // data lines carry a moving pattern outside answers
      noise <= {noise[14:0], noise[15] ^ noise[13]};
      locRdata <= ~noise;
      locReady <= 1'b0;
      if (locReq.valid && !locReady) begin
        waitCnt <= waitCnt + 4'h1;
        // slow answers when latency is raised
        if (waitCnt >= latency) begin
          locReady <= 1'b1;
          waitCnt <= 4'h0;
          locRdata <= mem.exists(key) ? mem[key] : 16'(key) ^ 16'h5A3C;
          // write lands as the access ends
          if (locReq.write) begin
            mem[key] = locReq.wdata;
          end
        end
      end
    end
  end
endmodule : ipma_loc_model

`default_nettype wire

// >>> sim/tb_top.sv
// self-checking testbench of the indirect private memory bridge
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] PRD = 6'b100011;
  localparam logic [5:0] PRDB = 6'b100001;
  localparam logic [5:0] PWR = 6'b010011;
  localparam logic [5:0] IRD = 6'b001010;
  localparam logic [5:0] IWR = 6'b000110;
  localparam logic [5:0] IRDB = 6'b001000;
  localparam logic [5:0] IWRB = 6'b000100;
  localparam logic [5:0] MRD = 6'b100010;
  localparam logic [5:0] MWR = 6'b010010;

  logic                     ref_clk;
  logic                     rst;
  ipma_pkg::ipma_host_req_t hostReq;
  ipma_pkg::ipma_host_rsp_t hostRsp;
  ipma_pkg::ipma_host_rsp_t rsp;
  ipma_pkg::ipma_loc_req_t  locReq;
  ipma_pkg::ipma_loc_req_t  seenLoc;
  logic                     locReady;
  logic [15:0]              locRdata;
  logic                     adapterOpen;
  logic [6:0]               pageSelect;
  logic [3:0]               latency;
  logic [31:0]              rd;
  logic [15:0]              val;
  logic [15:0]              refMem [int];
  logic [6:0]               codes [3] = '{ipma_pkg::PAGE_ROM_LO, ipma_pkg::PAGE_ROM_HI, ipma_pkg::PAGE_SRAM};
  logic [5:0]               ops [6] = '{PWR, PRD, MWR, MRD, IWR, IRD};
  logic [19:0]              adrs [6] = '{20'hD0100, 20'hD0100, 20'hCDE10, 20'hCDE10, 20'h01C8A, 20'h01C8A};
  int                       offs [7] = '{'hFE90, 'hFE8E, 'hFFFE, 'h1000, 'h1FFE, 'h2000, 'h0FFE};
  int                       num_errors;
  int                       compares;
  int                       cycles;
  int                       locCount;
  int                       lastCount;
  int                       retries;
  int                       seed;
  int                       off;
  int                       attnRef;
  int                       regionRef;
  int                       wopenRef;
  int                       wcloseRef;

  ipma_bridge u_ipma_bridge (.ref_clk(ref_clk), .rst(rst), .hostReq(hostReq), .hostRsp(hostRsp), .locReq(locReq),
    .locReady(locReady), .locRdata(locRdata), .adapterOpen(adapterOpen), .pageSelect(pageSelect));
  ipma_loc_model u_ipma_loc_model (.ref_clk(ref_clk), .rst(rst), .locReq(locReq), .locReady(locReady),
    .locRdata(locRdata), .latency(latency));

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (locReq.valid === 1'b1 && locReady === 1'b1) begin
      seenLoc <= locReq;
      locCount <= locCount + 1;
    end
    if (cycles == 30000) begin
      num_errors++;
      $display("wrong value at %0t: run hangs", $time);
      summarize();
    end
  end

  task chk(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk

  function automatic logic [15:0] refRd(input int k);
    return refMem.exists(k) ? refMem[k] : 16'(k) ^ 16'h5A3C;
  endfunction : refRd

  function automatic bit wrOk(input int o);
    if (attnRef[6]) return 1'b1;
    if (!adapterOpen) return 1'b0;
    return o >= regionRef || (o >= wopenRef && o < wcloseRef);
  endfunction : wrOk

  task access(input logic isWr, input logic [7:0] ofs, input logic [31:0] wd);
    @(negedge ref_clk);
    hostReq = '{req: 1'b1, wr: isWr, addr: ofs, wdata: wd};
    @(negedge ref_clk);
    hostReq.req = 1'b0;
    rsp = hostRsp;
    rd = hostRsp.rdata;
  endtask : access

  // reissue while the bridge answers with retry
  task retryOp(input logic isWr, input logic [7:0] ofs, input logic [31:0] wd);
    retries = 0;
    access(isWr, ofs, wd);
    while (rsp.retry === 1'b1 && retries < 100) begin
      retries++;
      access(isWr, ofs, wd);
    end
  endtask : retryOp

  task xfer(input logic [5:0] op, input logic [19:0] la, input logic [15:0] wd);
    // command slot stays busy while a posted local write finishes
    retryOp(1'b1, ipma_pkg::OFS_CMD_WORD, {op, 6'h00, la});
    retryOp(op[4] | op[2], ipma_pkg::OFS_DATA_PORT, {16'h0000, wd});
    chk(rsp.ack === 1'b1, "transfer not acknowledged");
  endtask : xfer

  task privWr(input int o);
    val = 16'($random(seed));
    xfer(PWR, 20'hD0000 | 20'(o), val);
    if (wrOk(o)) refMem[o >> 1] = val;
    xfer(PRD, 20'hD0000 | 20'(o), 16'h0000);
    chk(rd[15:0] === refRd(o >> 1), "protected memory content");
  endtask : privWr

  task summarize();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    seed = 12;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    locCount = 0;
    attnRef = 0;
    hostReq = '0;
    adapterOpen = 1'b0;
    latency = 4'h0;
    rst = 1'b1;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    xfer(IRDB, ipma_pkg::IO_ATTN_ADDR, 16'h0000);
    chk(rd[7:0] === ipma_pkg::ATTN_RESET, "attention reset");
    xfer(IWR, ipma_pkg::IO_PAGE_ADDR, 16'h01C0);
    xfer(IRD, ipma_pkg::IO_PAGE_ADDR, 16'h0000);
    chk(rd[15:0] === ipma_pkg::PAGE_RESET && pageSelect === 7'h00, "page register locked");
    $display("test reset and lock done");
    xfer(IWRB, ipma_pkg::IO_ATTN_ADDR, 16'h0080);
    for (int i = 0; i < 3; i++) begin
      xfer(IWR, ipma_pkg::IO_PAGE_ADDR, {7'h00, codes[i], 2'b00});
      xfer(IRD, ipma_pkg::IO_PAGE_ADDR, 16'h0000);
      chk(rd[15:0] === (ipma_pkg::PAGE_RESET | {7'h00, codes[i], 2'b00}), "page readback");
      chk(pageSelect === codes[i], "page select output");
      off = $random(seed) & 'hFFFE;
      xfer(PRD, 20'hD0000 | 20'(off), 16'h0000);
      chk(seenLoc.memAddr === {codes[i][6:3], 16'(off)} && seenLoc.addr === (20'hD0000 | 20'(off)), "paging");
      chk(rd[15:0] === refRd(int'({codes[i][6:3], 16'(off)} >> 1)), "paged read data");
    end
    $display("test paging done");
    xfer(IWRB, ipma_pkg::IO_ATTN_ADDR, 16'h00C0);
    attnRef = 'hC0;
    for (int i = 0; i < 6; i++) begin
      if (i % 2 == 0) val = 16'($random(seed));
      lastCount = locCount;
      xfer(ops[i], adrs[i], val);
      // let a posted local write reach its ready edge
      repeat (3) @(negedge ref_clk);
      chk(locCount == lastCount + 1 && seenLoc.addr === adrs[i] && seenLoc.word === 1'b1, "local access");
      chk(seenLoc.write === (ops[i][4] | ops[i][2]) && seenLoc.isIo === (ops[i][3] | ops[i][2]), "class");
      chk(seenLoc.isPriv === ops[i][0], "private class");
      if (i % 2 == 1) chk(rd[15:0] === val, "write then read");
    end
    xfer(PWR, 20'hD0100, 16'hC3A5);
    refMem['h80] = 16'hC3A5;
    xfer(PRDB, 20'hD0101, 16'h0000);
    chk(rd[15:0] === 16'h00C3 && seenLoc.word === 1'b0, "byte read odd");
    $display("test classes done");
    latency = 4'h6;
    access(1'b1, ipma_pkg::OFS_CMD_WORD, {PRD, 6'h3F, 20'hD0100});
    access(1'b1, ipma_pkg::OFS_CMD_WORD, {PWR, 6'h00, 20'hD0200});
    chk(rsp.retry === 1'b1, "second command not refused");
    access(1'b0, ipma_pkg::OFS_CMD_WORD, 32'h0000_0000);
    chk(rsp.ack === 1'b1 && rd === {PRD, 6'h00, 20'hD0100}, "command word readback");
    retryOp(1'b0, ipma_pkg::OFS_DATA_PORT, 32'h0000_0000);
    chk(retries > 0 && rsp.ack === 1'b1 && rd[15:0] === 16'hC3A5, "slow read");
    latency = 4'h2;
    access(1'b1, ipma_pkg::OFS_CMD_WORD, {PRD, 6'h00, 20'hD0100});
    access(1'b1, ipma_pkg::OFS_DATA_PORT, 32'h0000_1234);
    chk(rsp.abort === 1'b1, "write against read command");
    access(1'b0, ipma_pkg::OFS_DATA_PORT, 32'h0000_0000);
    chk(rsp.abort === 1'b1, "data access without command");
    access(1'b1, ipma_pkg::OFS_CMD_WORD, {PWR, 6'h00, 20'hD0100});
    access(1'b0, ipma_pkg::OFS_DATA_PORT, 32'h0000_0000);
    chk(rsp.abort === 1'b1, "read against write command");
    access(1'b0, 8'h20, 32'h0000_0000);
    chk(rsp.ack === 1'b1 && rd === 32'h0000_0000, "unmapped offset");
    $display("test pending and abort done");
    xfer(IWRB, ipma_pkg::IO_ATTN_ADDR, 16'h0000);
    attnRef = 0;
    privWr('hFE90);
    adapterOpen = 1'b1;
    regionRef = 'hFE90;
    xfer(MRD, ipma_pkg::MM_REGION_ADDR, 16'h0000);
    chk(rd[15:0] === 16'h90FE, "region origin after open");
    xfer(IWRB, ipma_pkg::IO_ATTN_ADDR, 16'h0040);
    xfer(MWR, ipma_pkg::MM_WOPEN_ADDR, 16'h0110);
    xfer(MWR, ipma_pkg::MM_WCLOSE_ADDR, 16'h0020);
    xfer(MRD, ipma_pkg::MM_WOPEN_ADDR, 16'h0000);
    chk(rd[15:0] === 16'h0010, "boundary alignment");
    xfer(IWRB, ipma_pkg::IO_ATTN_ADDR, 16'h0000);
    wopenRef = 'h1000;
    wcloseRef = 'h2000;
    for (int i = 0; i < 7; i++) privWr(offs[i]);
    xfer(IWRB, ipma_pkg::IO_ATTN_ADDR, 16'h0040);
    attnRef = 'h40;
    privWr('h0100);
    $display("test write protection done");
    summarize();
  end
endmodule : tb_top

`default_nettype wire
